/* File: tcw_map.vh */
// Register map, field layout and table geometry of the rule storage block
`ifndef TCW_MAP_VH
`define TCW_MAP_VH
`define TCW_ADDR_W 8
`define TCW_REG_UPDATE 8'h00
`define TCW_REG_RULE_ENA 8'h04
`define TCW_REG_COUNTER 8'h08
`define TCW_REG_ENTRY0 8'h10
`define TCW_REG_ENTRY1 8'h14
`define TCW_REG_MASK0 8'h18
`define TCW_REG_MASK1 8'h1c
`define TCW_REG_ACTION0 8'h20
`define TCW_REG_ACTION8 8'h40
`define TCW_CMD_HI 2
`define TCW_CMD_LO 0
`define TCW_CMD_WRITE 3'h4
`define TCW_UADDR_HI 15
`define TCW_UADDR_LO 3
`define TCW_CLEAR_BIT 16
`define TCW_TARGET_BIT 17
`define TCW_BUSY_BIT 31
`define TCW_TAB_AW 13
`define TCW_ROUTE_DEPTH 4096
`define TCW_ROUTE_LIMIT 13'h1000
`define TCW_WORD_W 36
`define TCW_ROUTE_ACT_W 70
`define TCW_ES_ENT_W 35
`define TCW_ES_ENT_LEN 9'h023
`define TCW_ES_ACT_W 285
`define TCW_ES_LARGE 13'h1000
`define TCW_ES_SMALL 13'h0800
`define TCW_ES_DEF_BASE 13'h1000
`define TCW_ES_DEF_NUM 6'h35
`define TCW_ES_DEPTH 4149
`define TCW_ES_LIMIT 13'h1035
`define TCW_ACT_WORDS 9
`define TCW_KEY_W 288
`define TCW_OP_STEPS 2
`endif

/* File: tcw_commit_seq.v */
// Commit sequencer: holds the operation-in-progress flag around one memory write
`timescale 1ns/1ps
`include "tcw_map.vh"
module tcw_commit_seq (
    input wire clk,
    input wire reset,
    input wire start,
    output wire memWrite,
    output wire busy
);
    localparam SQ_IDLE = 2'h0;
    localparam SQ_WRITE = 2'h1;
    localparam SQ_SETTLE = 2'h2;
    reg [1:0] state;
    reg [1:0] next_state;

    always @*
    begin
        next_state = state;
        case (state)
            SQ_IDLE: if (start) next_state = SQ_WRITE;
            SQ_WRITE: next_state = SQ_SETTLE;
            SQ_SETTLE: next_state = SQ_IDLE;
            default: next_state = SQ_IDLE;
        endcase
    end

    always @(posedge clk)
    begin
        if (reset)
            state <= SQ_IDLE;
        else
            state <= next_state;
    end

    assign memWrite = (state == SQ_WRITE);
    assign busy = (state != SQ_IDLE);
endmodule

/* File: tcw_word_match.v */
// Compare one stored address word against one key word
`timescale 1ns/1ps
`include "tcw_map.vh"
module tcw_word_match (
    input wire [35:0] storedEntry,
    input wire [35:0] storedMask,
    input wire [35:0] keyWord,
    input wire [8:0] bitBase,
    input wire [8:0] keyLen,
    output reg hit
);
    integer b;
    reg ok;
    reg [9:0] idx;

    always @*
    begin
        ok = 1'b1;
        idx = 10'h000;
        for (b = 0; b < `TCW_WORD_W; b = b + 1)
        begin
            idx = {1'b0, bitBase} + b[9:0];
            if (idx >= {1'b0, keyLen})
            begin
                if (keyWord[b]) ok = 1'b0;
            end
            else
            begin
                case ({storedEntry[b], storedMask[b]})
                    2'b00: ok = 1'b0;
                    2'b01: if (keyWord[b]) ok = 1'b0;
                    2'b10: if (!keyWord[b]) ok = 1'b0;
                    default: ok = ok;
                endcase
            end
        end
        hit = ok & (|(storedEntry | storedMask));
    end
endmodule

/* File: tcw_tcam_core.v */
// Rule cache, commit path and the routing-prefix and egress rewriter tables
//
// Notes on behaviour
// - Routing table has 4096 addresses, each 36 entry bits and 70 action bits.
// - Routing table keeps one-bit saturating hit counter; entry sizes 1, 2, 4, 8.
// - Routing entry bits follow the tag bits across consecutive addresses.
// - Routing table has no defaults; no match or no block means miss.
// - Egress table holds 35-bit entry, 285-bit action, one-bit counter, single size.
// - Egress table has 2048 addresses on small variant, 4096 otherwise.
// - Egress rule occupies one address, whole action beside the entry.
// - Egress has 53 default rules at 4096 plus n, used when nothing matches.
// - Unused upper entry bits of a narrow entry act as match-zero.
// - Cache-wipe control clears cached entry, mask, action and counter.
// - A cleared entry is match-off and never matches.
// - Command 4 with an in-range address shifted by 3 copies the cache to that address; an out-of-range address is ignored.
// - Once in-progress flag clears the rule is stored; an egress rule can match only if its enable bit was set.
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`include "tcw_map.vh"
module tcw_tcam_core #(
    parameter SMALL_VARIANT = 0
) (
    input wire clk,
    input wire reset,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    output reg [31:0] regRdData,
    input wire routeAssigned,
    input wire lookupStart,
    input wire lookupTable,
    input wire [287:0] lookupKey,
    input wire [1:0] lookupSize,
    input wire [8:0] lookupKeyLen,
    input wire [5:0] lookupDefault,
    output wire lookupBusy,
    output reg lookupDone,
    output reg lookupHit,
    output reg lookupMiss,
    output reg lookupDefaultHit,
    output reg [12:0] lookupAddr,
    output reg [284:0] lookupAction,
    output wire opInProgress
);
    localparam [12:0] ES_RULES = SMALL_VARIANT ? `TCW_ES_SMALL : `TCW_ES_LARGE;
    localparam LK_IDLE = 1'b0;
    localparam LK_SCAN = 1'b1;

    // Rule cache
    reg [31:0] entryWord0;
    reg [31:0] entryWord1;
    reg [31:0] maskWord0;
    reg [31:0] maskWord1;
    reg [31:0] actionCache [0:`TCW_ACT_WORDS-1];
    reg ruleEnable;
    reg cacheCounter;
    reg [12:0] commitAddr;
    reg commitTarget;

    // Table storage
    reg [35:0] routeEntry [0:`TCW_ROUTE_DEPTH-1];
    reg [35:0] routeMask [0:`TCW_ROUTE_DEPTH-1];
    reg [69:0] routeAction [0:`TCW_ROUTE_DEPTH-1];
    reg routeValid [0:`TCW_ROUTE_DEPTH-1];
    reg routeCount [0:`TCW_ROUTE_DEPTH-1];
    reg [34:0] egEntry [0:`TCW_ES_DEPTH-1];
    reg [34:0] egMask [0:`TCW_ES_DEPTH-1];
    reg [284:0] egAction [0:`TCW_ES_DEPTH-1];
    reg egValid [0:`TCW_ES_DEPTH-1];
    reg egEnable [0:`TCW_ES_DEPTH-1];
    reg egCount [0:`TCW_ES_DEPTH-1];

    // Lookup engine state
    reg lkState;
    reg scanTable;
    reg [12:0] scanBase;
    reg [2:0] scanOff;
    reg [3:0] sizeReg;
    reg [8:0] keyLenReg;
    reg [5:0] defIdx;
    reg [287:0] keyReg;

    reg [31:0] readValue;
    integer i;
    integer j;

    wire memWrite;
    wire cacheAccess = regWrite & ~opInProgress;
    wire isUpdate = (regAddr == `TCW_REG_UPDATE);
    wire [12:0] reqAddr = regWrData[`TCW_UADDR_HI:`TCW_UADDR_LO];
    wire reqTarget = regWrData[`TCW_TARGET_BIT];

    function [3:0] sizeOf;
        input [1:0] code;
        begin
            sizeOf = 4'h1 << code;
        end
    endfunction

    function [8:0] keyBase;
        input [2:0] off;
        begin
            keyBase = {6'h00, off} * 9'h024;
        end
    endfunction

    function addrOk;
        input tgt;
        input [12:0] a;
        begin
            if (tgt)
                addrOk = (a < ES_RULES) || ((a >= `TCW_ES_DEF_BASE) && (a < `TCW_ES_LIMIT));
            else
                addrOk = (a < `TCW_ROUTE_LIMIT);
        end
    endfunction

    function isActionReg;
        input [7:0] a;
        begin
            isActionReg = (a >= `TCW_REG_ACTION0) && (a <= `TCW_REG_ACTION8) && (a[1:0] == 2'b00);
        end
    endfunction

    function [3:0] actIndex;
        input [7:0] a;
        reg [7:0] d;
        begin
            d = a - `TCW_REG_ACTION0;
            actIndex = d[5:2];
        end
    endfunction

    wire commitStart = cacheAccess & isUpdate & (regWrData[`TCW_CMD_HI:`TCW_CMD_LO] == `TCW_CMD_WRITE) &
        addrOk(reqTarget, reqAddr);

    tcw_commit_seq commitSeq (
        .clk(clk),
        .reset(reset),
        .start(commitStart),
        .memWrite(memWrite),
        .busy(opInProgress)
    );

    // Scan datapath
    wire [12:0] scanAddr = scanBase + {10'h000, scanOff};
    wire [35:0] curEntry = scanTable ? {1'b0, egEntry[scanAddr]} : routeEntry[scanAddr[11:0]];
    wire [35:0] curMask = scanTable ? {1'b0, egMask[scanAddr]} : routeMask[scanAddr[11:0]];
    wire curValid = scanTable ? (egValid[scanAddr] & egEnable[scanAddr]) : routeValid[scanAddr[11:0]];
    wire [8:0] curBase = keyBase(scanOff);
    wire [35:0] curKey = keyReg[curBase +: 36];
    wire [8:0] lenUsed = scanTable ? `TCW_ES_ENT_LEN : keyLenReg;
    wire matchWord;
    wire wordHit = matchWord & curValid;
    wire lastOff = ({1'b0, scanOff} == (sizeReg - 4'h1));
    wire [12:0] nextBase = scanBase + {9'h000, sizeReg};
    wire [12:0] tableLimit = scanTable ? ES_RULES : `TCW_ROUTE_LIMIT;
    wire endReached = (nextBase + {9'h000, sizeReg}) > tableLimit;
    wire [12:0] defAddr = `TCW_ES_DEF_BASE + {7'h00, defIdx};

    tcw_word_match wordMatch (
        .storedEntry(curEntry),
        .storedMask(curMask),
        .keyWord(curKey),
        .bitBase(curBase),
        .keyLen(lenUsed),
        .hit(matchWord)
    );

    assign lookupBusy = (lkState != LK_IDLE);

    // Register read mux
    always @*
    begin
        readValue = 32'h00000000;
        if (regAddr == `TCW_REG_UPDATE)
            readValue = {opInProgress, 13'h0000, commitTarget, 1'b0, commitAddr, 3'h0};
        else if (regAddr == `TCW_REG_RULE_ENA)
            readValue = {31'h00000000, ruleEnable};
        else if (regAddr == `TCW_REG_COUNTER)
            readValue = {31'h00000000, cacheCounter};
        else if (regAddr == `TCW_REG_ENTRY0)
            readValue = entryWord0;
        else if (regAddr == `TCW_REG_ENTRY1)
            readValue = entryWord1;
        else if (regAddr == `TCW_REG_MASK0)
            readValue = maskWord0;
        else if (regAddr == `TCW_REG_MASK1)
            readValue = maskWord1;
        else if (isActionReg(regAddr))
            readValue = actionCache[actIndex(regAddr)];
    end

    // Register writes and cache
    always @(posedge clk)
    begin
        if (reset)
        begin
            regRdData <= 32'h00000000;
            entryWord0 <= 32'h00000000;
            entryWord1 <= 32'h00000000;
            maskWord0 <= 32'h00000000;
            maskWord1 <= 32'h00000000;
            ruleEnable <= 1'b0;
            cacheCounter <= 1'b0;
            commitAddr <= 13'h0000;
            commitTarget <= 1'b0;
            for (i = 0; i < `TCW_ACT_WORDS; i = i + 1)
                actionCache[i] <= 32'h00000000;
        end
        else
        begin
            regRdData <= regRead ? readValue : 32'h00000000;
            if (cacheAccess)
            begin
                if (isUpdate)
                begin
                    if (regWrData[`TCW_CLEAR_BIT])
                    begin
                        entryWord0 <= 32'h00000000;
                        entryWord1 <= 32'h00000000;
                        maskWord0 <= 32'h00000000;
                        maskWord1 <= 32'h00000000;
                        ruleEnable <= 1'b0;
                        cacheCounter <= 1'b0;
                        for (i = 0; i < `TCW_ACT_WORDS; i = i + 1)
                            actionCache[i] <= 32'h00000000;
                    end
                    if (commitStart)
                    begin
                        commitAddr <= reqAddr;
                        commitTarget <= reqTarget;
                    end
                end
                else if (regAddr == `TCW_REG_RULE_ENA)
                    ruleEnable <= regWrData[0];
                else if (regAddr == `TCW_REG_COUNTER)
                    cacheCounter <= regWrData[0];
                else if (regAddr == `TCW_REG_ENTRY0)
                    entryWord0 <= regWrData;
                else if (regAddr == `TCW_REG_ENTRY1)
                    entryWord1 <= regWrData;
                else if (regAddr == `TCW_REG_MASK0)
                    maskWord0 <= regWrData;
                else if (regAddr == `TCW_REG_MASK1)
                    maskWord1 <= regWrData;
                else if (isActionReg(regAddr))
                    actionCache[actIndex(regAddr)] <= regWrData;
            end
        end
    end

    // Cache copy into the selected table
    always @(posedge clk)
    begin
        if (memWrite)
        begin
            if (commitTarget)
            begin
                egEntry[commitAddr] <= {entryWord1[2:0], entryWord0};
                egMask[commitAddr] <= {maskWord1[2:0], maskWord0};
                egAction[commitAddr] <= {actionCache[8][28:0], actionCache[7], actionCache[6], actionCache[5],
                    actionCache[4], actionCache[3], actionCache[2], actionCache[1], actionCache[0]};
            end
            else
            begin
                routeEntry[commitAddr[11:0]] <= {entryWord1[3:0], entryWord0};
                routeMask[commitAddr[11:0]] <= {maskWord1[3:0], maskWord0};
                routeAction[commitAddr[11:0]] <= {actionCache[2][5:0], actionCache[1], actionCache[0]};
            end
        end
    end

    // Valid flags, hit counters and lookup engine
    always @(posedge clk)
    begin
        if (reset)
        begin
            lkState <= LK_IDLE;
            scanTable <= 1'b0;
            scanBase <= 13'h0000;
            scanOff <= 3'h0;
            sizeReg <= 4'h1;
            keyLenReg <= 9'h000;
            defIdx <= 6'h00;
            keyReg <= {`TCW_KEY_W{1'b0}};
            lookupDone <= 1'b0;
            lookupHit <= 1'b0;
            lookupMiss <= 1'b0;
            lookupDefaultHit <= 1'b0;
            lookupAddr <= 13'h0000;
            lookupAction <= {`TCW_ES_ACT_W{1'b0}};
            for (j = 0; j < `TCW_ROUTE_DEPTH; j = j + 1)
            begin
                routeValid[j] <= 1'b0;
                routeCount[j] <= 1'b0;
            end
            for (j = 0; j < `TCW_ES_DEPTH; j = j + 1)
            begin
                egValid[j] <= 1'b0;
                egEnable[j] <= 1'b0;
                egCount[j] <= 1'b0;
            end
        end
        else
        begin
            lookupDone <= 1'b0;
            if (memWrite)
            begin
                if (commitTarget)
                begin
                    egValid[commitAddr] <= 1'b1;
                    egEnable[commitAddr] <= ruleEnable;
                    egCount[commitAddr] <= cacheCounter;
                end
                else
                begin
                    routeValid[commitAddr[11:0]] <= 1'b1;
                    routeCount[commitAddr[11:0]] <= cacheCounter;
                end
            end
            case (lkState)
                LK_IDLE:
                begin
                    if (lookupStart)
                    begin
                        scanTable <= lookupTable;
                        scanBase <= 13'h0000;
                        scanOff <= 3'h0;
                        sizeReg <= lookupTable ? 4'h1 : sizeOf(lookupSize);
                        keyLenReg <= lookupKeyLen;
                        defIdx <= lookupDefault;
                        keyReg <= lookupKey;
                        if (!lookupTable && !routeAssigned)
                        begin
                            lookupDone <= 1'b1;
                            lookupHit <= 1'b0;
                            lookupMiss <= 1'b1;
                            lookupDefaultHit <= 1'b0;
                            lookupAddr <= 13'h0000;
                            lookupAction <= {`TCW_ES_ACT_W{1'b0}};
                        end
                        else
                            lkState <= LK_SCAN;
                    end
                end
                LK_SCAN:
                begin
                    if (wordHit && lastOff)
                    begin
                        lkState <= LK_IDLE;
                        lookupDone <= 1'b1;
                        lookupHit <= 1'b1;
                        lookupMiss <= 1'b0;
                        lookupDefaultHit <= 1'b0;
                        lookupAddr <= scanBase;
                        if (scanTable)
                        begin
                            lookupAction <= egAction[scanBase];
                            egCount[scanBase] <= 1'b1;
                        end
                        else
                        begin
                            lookupAction <= {215'h0, routeAction[scanBase[11:0]]};
                            routeCount[scanBase[11:0]] <= 1'b1;
                        end
                    end
                    else if (wordHit)
                        scanOff <= scanOff + 3'h1;
                    else if (endReached)
                    begin
                        lkState <= LK_IDLE;
                        lookupDone <= 1'b1;
                        if (scanTable && (defIdx < `TCW_ES_DEF_NUM))
                        begin
                            lookupHit <= 1'b0;
                            lookupMiss <= 1'b0;
                            lookupDefaultHit <= 1'b1;
                            lookupAddr <= defAddr;
                            lookupAction <= egAction[defAddr];
                            egCount[defAddr] <= 1'b1;
                        end
                        else
                        begin
                            lookupHit <= 1'b0;
                            lookupMiss <= 1'b1;
                            lookupDefaultHit <= 1'b0;
                            lookupAddr <= 13'h0000;
                            lookupAction <= {`TCW_ES_ACT_W{1'b0}};
                        end
                    end
                    else
                    begin
                        scanBase <= nextBase;
                        scanOff <= 3'h0;
                    end
                end
                default: lkState <= LK_IDLE;
            endcase
        end
    end
endmodule

/* File: tcw_core_monitor.sv */
// Port checker for the rule storage block
`timescale 1ns/1ps
module tcw_core_monitor #(
    parameter SMALL_VARIANT = 0
) (
    input wire clk,
    input wire reset,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWrite,
    input wire regRead,
    input wire [31:0] regRdData,
    input wire routeAssigned,
    input wire lookupStart,
    input wire lookupTable,
    input wire lookupBusy,
    input wire lookupDone,
    input wire lookupHit,
    input wire lookupMiss,
    input wire lookupDefaultHit,
    input wire [12:0] lookupAddr,
    input wire [284:0] lookupAction,
    input wire opInProgress
);
    localparam [12:0] ES_SIZE = SMALL_VARIANT ? 13'h0800 : 13'h1000;
    reg lastTable;
    wire ctrlWr = regWrite && regAddr == 8'h00;
    always @(posedge clk)
    begin
        if (reset)
            lastTable <= 1'b0;
        else if (lookupStart && !lookupBusy)
            lastTable <= lookupTable;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    property p_commitBusy;
        ctrlWr && regWrData[2:0] == 3'h4 && !regWrData[17] && regWrData[15:3] < 13'h1000 && !opInProgress
            |=> opInProgress [*2] ##1 !opInProgress;
    endproperty
    a_commitBusy: assert property (p_commitBusy) else $error("commit busy window wrong");
    property p_noSpurious;
        !opInProgress && !ctrlWr |=> !opInProgress;
    endproperty
    a_noSpurious: assert property (p_noSpurious) else $error("busy without commit");
    property p_busyRead;
        regRead && regAddr == 8'h00 && opInProgress |=> regRdData[31];
    endproperty
    a_busyRead: assert property (p_busyRead) else $error("busy flag not readable");
    property p_clearRead;
        ctrlWr && regWrData[16] && !opInProgress ##1 !regWrite ##1 regRead && regAddr == 8'h10 |=> regRdData == 32'h0;
    endproperty
    a_clearRead: assert property (p_clearRead) else $error("cache not wiped");
    property p_noBlock;
        lookupStart && !lookupBusy && !lookupTable && !routeAssigned |=> lookupDone && lookupMiss;
    endproperty
    a_noBlock: assert property (p_noBlock) else $error("unassigned lookup not a miss");
    property p_missAddr;
        lookupDone && lookupMiss |-> lookupAddr == 13'h0 && !lookupHit && !lookupDefaultHit;
    endproperty
    a_missAddr: assert property (p_missAddr) else $error("miss result wrong");
    property p_routeNoDefault;
        lookupDone && !lastTable |-> !lookupDefaultHit && lookupAction[284:70] == 215'h0;
    endproperty
    a_routeNoDefault: assert property (p_routeNoDefault) else $error("routing result wrong");
    property p_esRange;
        lookupDone && lastTable && lookupHit |-> lookupAddr < ES_SIZE;
    endproperty
    a_esRange: assert property (p_esRange) else $error("egress hit out of range");
    property p_defaultAddr;
        lookupDone && lookupDefaultHit |-> lastTable && lookupAddr >= 13'h1000 && lookupAddr < 13'h1035;
    endproperty
    a_defaultAddr: assert property (p_defaultAddr) else $error("default address wrong");
    c_commit: cover property (ctrlWr && regWrData[2:0] == 3'h4 ##1 opInProgress);
    c_routeHit: cover property (lookupDone && lookupHit && !lastTable);
    c_default: cover property (lookupDone && lookupDefaultHit);
    c_miss: cover property (lookupDone && lookupMiss);
endmodule
bind tcw_tcam_core tcw_core_monitor #(.SMALL_VARIANT(SMALL_VARIANT)) mon (.clk(clk), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .routeAssigned(routeAssigned), .lookupStart(lookupStart), .lookupTable(lookupTable), .lookupBusy(lookupBusy),
    .lookupDone(lookupDone), .lookupHit(lookupHit), .lookupMiss(lookupMiss), .lookupDefaultHit(lookupDefaultHit),
    .lookupAddr(lookupAddr), .lookupAction(lookupAction), .opInProgress(opInProgress));

/* File: test_tcw_tcam_core.sv */
// Self-checking testbench for the rule storage block
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_tcw_tcam_core;
    logic clk = 0, reset = 1, regWrite = 0, regRead = 0, routeAssigned = 0, lookupStart = 0, lookupTable = 0;
    logic [7:0] regAddr = 0;
    logic [31:0] regWrData = 0, regRdData;
    logic [287:0] lookupKey = 0;
    logic [1:0] lookupSize = 0;
    logic [8:0] lookupKeyLen = 0;
    logic [5:0] lookupDefault = 0;
    logic lookupBusy, lookupDone, lookupHit, lookupMiss, lookupDefaultHit, opInProgress;
    logic [12:0] lookupAddr;
    logic [284:0] lookupAction;
    integer err_total = 0, total_checks = 0, cycles = 0;
    logic [31:0] d;
    localparam [35:0] W = 36'h9_1234_5679, W1 = {35'h1_2345_6789, 1'b0}, W0 = {34'h3_0f0f_0f0f, 2'b10};
    localparam [287:0] RA = {218'h0, 70'h2a_1234_5678_cafe_0001}, RB = {218'h0, 70'h15_8765_4321_0bad_f00d};
    localparam [287:0] EA = {3'h0, 29'h1abcdef0, {4{64'h0123_4567_89ab_cdef}}};
    localparam [34:0] E = 35'h5_1357_9bdf;
    tcw_tcam_core #(.SMALL_VARIANT(1)) dut (.clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .routeAssigned(routeAssigned),
        .lookupStart(lookupStart), .lookupTable(lookupTable), .lookupKey(lookupKey), .lookupSize(lookupSize),
        .lookupKeyLen(lookupKeyLen), .lookupDefault(lookupDefault), .lookupBusy(lookupBusy),
        .lookupDone(lookupDone), .lookupHit(lookupHit), .lookupMiss(lookupMiss),
        .lookupDefaultHit(lookupDefaultHit), .lookupAddr(lookupAddr), .lookupAction(lookupAction),
        .opInProgress(opInProgress));
    initial
    begin
        forever #50 clk = ~clk;
    end
    task tally_and_finish;
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            err_total++;
            tally_and_finish;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWrData <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 v = regRdData;
    endtask
    task automatic idle;
        integer n;
        d = 32'hffffffff;
        for (n = 0; n < 50 && d[31] !== 1'b0; n++)
            rd(8'h00, d);
        `CHK(d[31], 1'b0)
    endtask
    task automatic commit(input logic t, input logic [12:0] a);
        wr(8'h00, {14'h0, t, 1'b0, a, 3'h4});
    endtask
    task automatic prog(input logic t, input logic [12:0] a, input logic [35:0] e, input logic [287:0] act,
        input logic ena);
        integer i;
        idle();
        wr(8'h00, 32'h0001_0000);
        wr(8'h10, e[31:0]);
        wr(8'h14, {28'h0, e[35:32]});
        wr(8'h18, ~e[31:0]);
        wr(8'h1c, {28'h0, ~e[35:32]});
        for (i = 0; i < 9; i++)
            wr(8'(8'h20 + 4 * i), act[32 * i +: 32]);
        wr(8'h04, {31'h0, ena});
        commit(t, a);
    endtask
    task automatic look(input logic t, input logic [287:0] k, input logic [1:0] s, input logic [8:0] n,
        input logic [5:0] df);
        integer i;
        @(posedge clk);
        lookupTable <= t;
        lookupKey <= k;
        lookupSize <= s;
        lookupKeyLen <= n;
        lookupDefault <= df;
        lookupStart <= 1'b1;
        @(posedge clk);
        lookupStart <= 1'b0;
        #1 `CHK(lookupBusy, t | routeAssigned)
        for (i = 0; i < 5000; i++)
        begin
            #1;
            if (lookupDone === 1'b1)
                break;
            @(posedge clk);
        end
        `CHK(lookupDone, 1'b1)
        `CHK(lookupBusy, 1'b0)
    endtask
    task automatic res(input logic h, input logic m, input logic dh, input logic [12:0] a);
        `CHK({lookupHit, lookupMiss, lookupDefaultHit, lookupAddr}, {h, m, dh, a})
    endtask
    task automatic t_regs;
        logic [7:0] a[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'hfc};
        foreach (a[i])
        begin
            rd(a[i], d);
            `CHK(d, 32'h0)
        end
        wr(8'h10, 32'h1234_5678);
        rd(8'h10, d);
        `CHK(d, 32'h1234_5678)
        wr(8'h00, 32'h0001_0000);
        rd(8'h10, d);
        `CHK(d, 32'h0)
    endtask
    task automatic t_route;
        routeAssigned <= 1'b1;
        prog(1'b0, 13'h0008, W, RA, 1'b0);
        rd(8'h00, d);
        `CHK(d[31], 1'b1)
        `CHK(opInProgress, 1'b0)
        idle();
        look(1'b0, {252'h0, W}, 2'h0, 9'h024, 6'h3f);
        res(1'b1, 1'b0, 1'b0, 13'h0008);
        `CHK(lookupAction, RA[284:0])
        look(1'b0, {252'h0, W ^ 36'h2}, 2'h0, 9'h024, 6'h3f);
        res(1'b0, 1'b1, 1'b0, 13'h0);
        prog(1'b0, 13'h0011, W1, RA, 1'b0);
        prog(1'b0, 13'h0010, W0, RB, 1'b0);
        idle();
        look(1'b0, {216'h0, W1, W0}, 2'h1, 9'h048, 6'h3f);
        res(1'b1, 1'b0, 1'b0, 13'h0010);
        `CHK(lookupAction, RB[284:0])
        routeAssigned <= 1'b0;
        look(1'b0, {252'h0, W}, 2'h0, 9'h024, 6'h3f);
        res(1'b0, 1'b1, 1'b0, 13'h0);
    endtask
    task automatic t_egress;
        prog(1'b1, 13'h0003, {1'b0, E}, EA, 1'b1);
        prog(1'b1, 13'h0004, {1'b0, E ^ 35'h1}, EA, 1'b0);
        prog(1'b1, 13'h1034, 36'h0, RB, 1'b1);
        idle();
        look(1'b1, {253'h0, E}, 2'h0, 9'h023, 6'h00);
        res(1'b1, 1'b0, 1'b0, 13'h0003);
        `CHK(lookupAction, EA[284:0])
        look(1'b1, {253'h0, E ^ 35'h1}, 2'h0, 9'h023, 6'h34);
        res(1'b0, 1'b0, 1'b1, 13'h1034);
        `CHK(lookupAction, RB[284:0])
        look(1'b1, {253'h0, E ^ 35'h1}, 2'h0, 9'h023, 6'h35);
        res(1'b0, 1'b1, 1'b0, 13'h0);
        commit(1'b1, 13'h0800);
        rd(8'h00, d);
        `CHK(d[31], 1'b0)
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_route();
        t_egress();
        tally_and_finish;
    end
endmodule
